/* common/dac_front_pkg.sv */
/*
  Shared constants for the serial converter front end: frame layout,
  operating modes, APB register map and timing counts.
  Assumes a 200 MHz system clock and 32-bit APB data.
*/
package dac_front_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int FRAME_BITS     = 24;
  localparam int DATA_BITS      = 16;
  localparam int MODE_HI_POS    = 17;
  localparam int MODE_LO_POS    = 16;
  localparam int PREFIX_LSB     = 18;
  localparam int CNT_W          = 5;

  // ****************************************************************
  // Operating modes
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'h0,
    MODE_PD_1K    = 2'h1,
    MODE_PD_100K  = 2'h2,
    MODE_PD_HIZ   = 2'h3
  } op_mode_t;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] ADDR_DATA     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_COUNT    = 12'h008;
  localparam logic [11:0] ADDR_CONTROL  = 12'h00C;
  localparam int          ST_MODE_POS   = 0;
  localparam int          ST_READY_POS  = 2;
  localparam int          ST_PREFIX_POS = 3;
  localparam int          ST_EN_POS     = 4;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ         = 200;
  localparam int WAKE_5V_NS      = 2500;
  localparam int WAKE_3V_NS      = 5000;
  localparam int WAKE_5V_CYCLES  = (WAKE_5V_NS * CLK_MHZ) / 1000;
  localparam int WAKE_3V_CYCLES  = (WAKE_3V_NS * CLK_MHZ) / 1000;

endpackage

/* hw/dac_frame_shifter.sv */
/*
  Serial frame capture on the link clock. Shifts data on falling
  edges of the shift clock while frame-select is low and emits the
  completed word with a toggle. Assumes frame-select resets the
  shift state asynchronously while high.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_frame_shifter
  import dac_front_pkg::*;
(
  input  wire logic                  sclk,
  input  wire logic                  nrst,
  input  wire logic                  frame_n,
  input  wire logic                  sdata,
  output logic [FRAME_BITS-1:0]      word,
  output logic                       done_toggle
);

  logic [FRAME_BITS-1:0] shift;
  logic [CNT_W-1:0]      count;
  logic                  active_rst_n;
  wire                   last_bit = (count == CNT_W'(FRAME_BITS - 1));
  wire  [FRAME_BITS-1:0] next_shift = {shift[FRAME_BITS-2:0], sdata};

  // High frame-select aborts; no sclk edge is assumed between frames
  assign active_rst_n = nrst & ~frame_n;

  always_ff @(negedge sclk or negedge active_rst_n) begin
    if (!active_rst_n) begin
      shift <= '0; // R6
      count <= '0;
    end else if (count != CNT_W'(FRAME_BITS)) begin
      shift <= next_shift; // R11 R1
      count <= count + CNT_W'(1);
    end
  end

  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      word        <= '0;
      done_toggle <= 1'b0;
    end else if (!frame_n && last_bit) begin
      word        <= next_shift; // R3
      done_toggle <= ~done_toggle;
    end
  end

endmodule
`default_nettype wire

/* hw/dac_front.sv */
/*
  Digital front end of a 16-bit voltage-output converter: serial frame
  input on its own clock, data and mode registers, power-down output
  terminations and wake-up timing, with an APB view of the state.
  Assumes the host drives frame-select, shift clock and data, and
  nrst stands for power-on reset.
*/
// Operation
// R1 - Frames are captured in a shift register exactly 24 bits long.
// R2 - Host sends six leading zero bits in every frame.
// R3 - Last 16 bits load the data register on 24th falling edge.
// R4 - Bits 17 and 16 choose normal, 1k, 100k or high impedance.
// R5 - Host keeps frame-select low for 24 falling edges.
// R6 - Early frame-select rise clears shifter, changes nothing else.
// R7 - Power-up clears all registers; output zero until valid frame. Code resets supply_low to 1 (CONTROL_RESET).
// R8 - Power-down disconnects amplifier and applies chosen termination.
// R9 - Power-down stops analog parts but keeps the data register.
// R10 - Leaving power-down gives valid output after 2.5 us or 5 us.
// R11 - While frame-select low, data sampled on each falling edge.
// R12 - Host holds frame-select high 33 ns between frames.
// R13 - Host sends most significant bit first.
// R14 - Mode and data apply together on the completing edge.
`timescale 1ns/1ps
`default_nettype none
module dac_front
  import dac_front_pkg::*;
#(
  parameter int WAKE_5V = WAKE_5V_CYCLES,
  parameter int WAKE_3V = WAKE_3V_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   sclk,
  input  wire logic                   frame_n,
  input  wire logic                   sdata,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic      [DATA_BITS-1:0]   dac_code,
  output logic                        amp_enable,
  output logic                        term_1k,
  output logic                        term_100k,
  output logic                        output_valid
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  initial begin
    if (WAKE_5V < 1 || WAKE_3V < 1 || WAKE_3V > 65535) begin
      $error("wake-up counts out of range");
    end
  end

  // ****************************************************************
  // Link domain
  // ****************************************************************
  logic [FRAME_BITS-1:0] link_word;
  logic                  link_toggle;

  dac_frame_shifter u_shifter (
    .sclk        (sclk),
    .nrst        (nrst),
    .frame_n     (frame_n),
    .sdata       (sdata),
    .word        (link_word),
    .done_toggle (link_toggle)
  );

  // ****************************************************************
  // Crossing: toggle synchroniser, word stable while toggle settles
  // ****************************************************************
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  wire  frame_done = tog_s2 ^ tog_s3;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      tog_s1 <= link_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  // Host spacing of 33 ns keeps the word steady through the capture
  logic [FRAME_BITS-1:0] word_hold;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_hold <= '0;
    end else begin
      word_hold <= link_word;
    end
  end

  // ****************************************************************
  // Data and mode registers
  // ****************************************************************
  op_mode_t              mode;
  logic [DATA_BITS-1:0]  data_reg;
  logic                  frame_seen;
  logic                  prefix_bad;
  logic                  supply_low;
  logic [15:0]           frame_count;

  wire op_mode_t         next_mode =
    op_mode_t'({word_hold[MODE_HI_POS], word_hold[MODE_LO_POS]}); // R4
  wire [DATA_BITS-1:0]   next_data = word_hold[DATA_BITS-1:0];
  wire                   prefix_nz = |word_hold[FRAME_BITS-1:PREFIX_LSB];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode        <= MODE_NORMAL; // R7
      data_reg    <= '0;
      frame_seen  <= 1'b0;
      prefix_bad  <= 1'b0;
      frame_count <= '0;
    end else if (frame_done) begin
      mode        <= next_mode; // R14
      data_reg    <= next_data; // R3 R14
      frame_seen  <= 1'b1;
      prefix_bad  <= prefix_nz; // R2
      frame_count <= frame_count + 16'h0001;
    end
  end

  // ****************************************************************
  // Power-down and wake-up timing
  // ****************************************************************
  logic [15:0] wake_cnt;
  wire         powered   = (mode == MODE_NORMAL);
  wire  [15:0] wake_load = supply_low ? 16'(WAKE_3V) : 16'(WAKE_5V);
  wire         wake_busy = (wake_cnt != 16'h0000);
  wire         leaving   = frame_done && !powered &&
                           (next_mode == MODE_NORMAL);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wake_cnt <= '0;
    end else if (leaving) begin
      wake_cnt <= wake_load; // R10
    end else if (wake_busy) begin
      wake_cnt <= wake_cnt - 16'h0001;
    end
  end

  // Outputs: code held through power-down, only the stage switches
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dac_code     <= '0; // R7
      amp_enable   <= 1'b0;
      term_1k      <= 1'b0;
      term_100k    <= 1'b0;
      output_valid <= 1'b0;
    end else begin
      dac_code     <= data_reg; // R9
      amp_enable   <= powered; // R8
      term_1k      <= (mode == MODE_PD_1K); // R8
      term_100k    <= (mode == MODE_PD_100K); // R8
      output_valid <= powered && frame_seen && !wake_busy && !leaving;
    end
  end

  // ****************************************************************
  // APB slave, zero wait states
  // ****************************************************************
  wire        setup    = psel && !penable;
  wire        wr_en    = psel && penable && pwrite;
  wire        hit_data = (paddr == ADDR_DATA);
  wire        hit_st   = (paddr == ADDR_STATUS);
  wire        hit_cnt  = (paddr == ADDR_COUNT);
  wire        hit_ctl  = (paddr == ADDR_CONTROL);
  wire        mapped   = hit_data | hit_st | hit_cnt | hit_ctl;
  wire [31:0] status   = (32'(mode) << ST_MODE_POS) |
                         (32'(output_valid) << ST_READY_POS) |
                         (32'(prefix_bad) << ST_PREFIX_POS) |
                         (32'(amp_enable) << ST_EN_POS);
  wire [31:0] rd_mux   = hit_data ? 32'(data_reg) :
                         hit_st   ? status :
                         hit_cnt  ? 32'(frame_count) :
                         hit_ctl  ? 32'(supply_low) : 32'h0000_0000;

  // Control bit 0 chooses the slower 3 V wake-up time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      supply_low <= CONTROL_RESET[0];
    end else if (wr_en && hit_ctl) begin
      supply_low <= pwdata[0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= (setup && !pwrite) ? rd_mux : prdata;
      pready  <= setup;
      pslverr <= setup && !mapped;
    end
  end

endmodule
`default_nettype wire

/* verification/host_link.sv */
/* Host model for the serial link: frame-select, shift clock, data.
   Assumes the bench calls send and nothing else drives these pins. */
`timescale 1ns/1ps
`default_nettype none
module host_link (
  output logic sclk,
  output logic frame_n,
  output logic sdata
);
  initial begin
    sclk = 1'b1;
    frame_n = 1'b1;
    sdata = 1'b0;
  end
  // Clock stands still between frames; fewer than 24 edges aborts
  task automatic send(input logic [23:0] w, input int n);
    frame_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdata = (i < 24) ? w[23-i] : 1'b0;
      #3 sclk = 1'b0;
      #3 sclk = 1'b1;
    end
    frame_n = 1'b1;
    sdata = ~sdata;
    #36;
  endtask
endmodule
`default_nettype wire

/* verification/dac_front_properties.sv */
/* Port assertions for the converter front end.
   Assumes binding to dac_front; all checks on the system clock. */
`timescale 1ns/1ps
`default_nettype none
module dac_front_properties
  import dac_front_pkg::*;
#(
  parameter int WAKE_5V = 4,
  parameter int WAKE_3V = 8
) (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 frame_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [DATA_BITS-1:0] dac_code,
  input wire logic                 amp_enable,
  input wire logic                 term_1k,
  input wire logic                 term_100k,
  input wire logic                 output_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  int amp_cnt;
  // Cycles the amplifier has been on, for the wake bound
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) amp_cnt <= 0;
    else amp_cnt <= amp_enable ? amp_cnt + 1 : 0;
  sequence s_setup; psel && !penable; endsequence
  sequence s_idle; frame_n [*8]; endsequence
  property p_reset_zero;
    disable iff (1'b0) !nrst |-> dac_code == '0 && !output_valid
      && !amp_enable && !term_1k && !term_100k;
  endproperty
  property p_term_one; term_1k |-> !term_100k && !amp_enable; endproperty
  property p_amp_free; amp_enable |-> !term_1k && !term_100k; endproperty
  property p_valid_amp; output_valid |-> amp_enable; endproperty
  property p_wake; $rose(output_valid) |-> amp_cnt >= WAKE_5V - 1; endproperty
  // Long idle link means every code, amplifier and termination update has landed
  property p_idle_stable;
    s_idle |=> $stable({dac_code, amp_enable, term_1k, term_100k});
  endproperty
  property p_answer; s_setup |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("not reset");
  a_term_one: assert property (p_term_one) else $error("bad 1k");
  a_amp_free: assert property (p_amp_free) else $error("bad amp");
  a_valid_amp: assert property (p_valid_amp) else $error("bad valid");
  a_wake: assert property (p_wake) else $error("early valid");
  a_idle_stable: assert property (p_idle_stable) else $error("drift");
  a_answer: assert property (p_answer) else $error("no ready");
  a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
  a_err_ready: assert property (p_err_ready) else $error("lone error");
endmodule
bind dac_front dac_front_properties #(
  .WAKE_5V(WAKE_5V),
  .WAKE_3V(WAKE_3V)
) u_props (
  .clk(clk), .nrst(nrst), .frame_n(frame_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .dac_code(dac_code), .amp_enable(amp_enable), .term_1k(term_1k),
  .term_100k(term_100k), .output_valid(output_valid)
);
`default_nettype wire

/* verification/tb.sv */
/* Self-checking bench for dac_front with the serial host model.
   Assumes wake counts shortened to 4 and 8 cycles. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dac_front_pkg::*;
  logic                 clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic                 sclk, frame_n, sdata, amp_enable, term_1k;
  logic                 term_100k, output_valid, rerr;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [DATA_BITS-1:0] dac_code;
  logic [15:0]          rnd;
  int errors, n_compared, cyc, m_code, m_mode, m_cnt, m_valid, m_pref;
  host_link host (.sclk(sclk), .frame_n(frame_n), .sdata(sdata));
  dac_front #(.WAKE_5V(4), .WAKE_3V(8)) dut (
    .clk(clk), .nrst(nrst), .sclk(sclk), .frame_n(frame_n),
    .sdata(sdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dac_code(dac_code), .amp_enable(amp_enable),
    .term_1k(term_1k), .term_100k(term_100k),
    .output_valid(output_valid));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check_all;
    check(dac_code, m_code);
    check(term_1k, m_mode == 1);
    check(term_100k, m_mode == 2);
    check(amp_enable, m_mode == 0);
    check(output_valid, m_valid);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, {m_mode == 0, m_pref[0], m_valid[0], m_mode[1:0]});
    apb(1'b0, ADDR_COUNT, 32'h0);
    check(rd, m_cnt);
  endtask
  // Model follows only complete frames; short ones leave it alone
  task automatic frame(input logic [23:0] w, input int n);
    int leaving;
    leaving = n >= 24 && m_mode != 0 && w[17:16] == 2'h0;
    host.send(w, n);
    if (n >= 24) begin
      m_valid = w[17:16] == 2'h0;
      m_code = w[15:0];
      m_mode = w[17:16];
      m_pref = w[23:18] != 6'h00;
      m_cnt++;
    end
    // Wake takes 8 cycles, so valid must still be low here
    if (leaving) check(output_valid, 1'b0);
    repeat (30) @(posedge clk);
    check_all;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish;
    end
  end
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    rnd = 16'h005C;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    check_all;
    apb(1'b0, ADDR_CONTROL, 32'h0);
    check(rd, CONTROL_RESET);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      frame({6'h00, 2'(i), rnd}, 24 + i / 4 * 2);
    end
    rnd = lfsr(rnd);
    frame({6'h00, 2'h1, rnd}, 23);
    frame({6'h00, 2'h2, ~rnd}, 12);
    frame({6'h2A, 2'h0, rnd}, 24);
    apb(1'b1, ADDR_DATA, 32'h0000_FFFF);
    apb(1'b0, ADDR_DATA, 32'h0);
    check(rd, m_code);
    apb(1'b0, 12'h010, 32'h0);
    check(32'(rerr), 32'h0000_0001);
    check(rd, 32'h0000_0000);
    apb(1'b1, ADDR_CONTROL, 32'h0);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    check(rd, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
